// File: verilog/bps_pkg.sv
package bps_pkg;

	// register map: the command/status dword, bytes 0x04..0x07
	localparam int unsigned BPS_ADDR_W = 8;
	localparam logic [BPS_ADDR_W-1:0] BPS_CMDSTS_OFFSET = 8'h04;
	localparam logic [31:0] BPS_DATA_ZERO = 32'h0000_0000;

	// command half-word: only the parity error response enable is held here
	localparam int unsigned BPS_CMD_PERR_RESP_BIT = 6;
	localparam logic BPS_PERR_RESP_RESET = 1'h0;

	// status half-word field positions within the 32-bit dword
	localparam int unsigned BPS_STS_LSB = 16;
	localparam int unsigned BPS_STS_INTX_BIT = 19;
	localparam int unsigned BPS_STS_CAPLIST_BIT = 20;
	localparam int unsigned BPS_STS_66MHZ_BIT = 21;
	localparam int unsigned BPS_STS_FB2B_BIT = 23;
	localparam int unsigned BPS_STS_DEVSEL_LSB = 25;
	localparam int unsigned BPS_STS_DEVSEL_MSB = 26;

	// capability list pointer location advertised by the capability bit
	localparam logic [7:0] BPS_CAP_PTR_OFFSET = 8'h34;
	localparam logic BPS_CAPLIST_VALUE = 1'h1;

	// device-select decode speed codes
	localparam logic [1:0] BPS_DEVSEL_FAST = 2'h0;
	localparam logic [1:0] BPS_DEVSEL_MEDIUM = 2'h1;
	localparam logic [1:0] BPS_DEVSEL_SLOW = 2'h2;

	// sticky flags: index into the flag vector and bit position in the dword
	localparam int unsigned BPS_NFLAGS = 6;
	localparam int unsigned BPS_F_MDPE = 0;
	localparam int unsigned BPS_F_STA = 1;
	localparam int unsigned BPS_F_RTA = 2;
	localparam int unsigned BPS_F_RMA = 3;
	localparam int unsigned BPS_F_SSE = 4;
	localparam int unsigned BPS_F_DPE = 5;
	localparam int unsigned BPS_FLAG_POS [0:BPS_NFLAGS-1] = '{24, 27, 28, 29, 30, 31};
	localparam logic [BPS_NFLAGS-1:0] BPS_FLAGS_RESET = 6'h00;

	// bridge direction
	localparam logic BPS_MODE_FORWARD = 1'h0;
	localparam logic BPS_MODE_REVERSE = 1'h1;

	// events from the forwarding logic, one-cycle pulses on the core clock
	typedef struct packed {
		logic fw_cpl_poisoned_rx;   // completion received poisoned
		logic fw_wr_poisoned_tx;    // write request sent poisoned
		logic fw_cpl_ca_tx;         // request completed with completer abort
		logic fw_cpl_ca_rx;         // completion received with completer abort
		logic fw_cpl_ur_rx;         // completion received with unsupported request
		logic fw_err_msg_tx;        // fatal or non-fatal error message sent
		logic fw_poisoned_tlp_rx;   // any poisoned packet received
		logic rv_rd_data_perr;      // parity error on read data or split response for read
		logic rv_scm_npw_perr;      // split completion message: data parity error, np write
		logic rv_target_abort_tx;   // bridge terminated a transaction with target abort
		logic rv_target_abort_rx;   // mastered transaction ended in target abort
		logic rv_master_abort_rx;   // mastered transaction ended in master abort
		logic rv_serr_driven;       // bridge drove the system error pin
		logic rv_addr_data_perr;    // address or data parity error detected
	} bps_evt_t;

endpackage : bps_pkg

// File: verilog/bps_top.sv
// Summary of operation
// - bit 19 shows whether an INTx message request is pending; read-only.
// - bit 20 always reads 1: capability list present, pointer at 34h.
// - bit 21 reads 0 in forward mode, 1 in reverse mode.
// - bit 23 reads 1 only in reverse mode with PCI primary bus, else 0.
// - bit 24 may only be set while parity error response enable is 1.
// - forward: poisoned completion received or poisoned write sent sets bit 24.
// - reverse: parity error on read data or split response for read sets bit 24.
// - reverse: parity error pin seen while sending or split write response sets 24.
// - reverse: split completion message reporting non-posted write parity error sets 24.
// - bits 26:25 give decode speed: 00 in forward mode, 01 in reverse.
// - forward: completing a request with completer abort sets bit 27.
// - reverse: terminating a primary transaction with target abort sets bit 27.
// - forward: completion received with completer abort sets bit 28.
// - reverse: mastered transaction ending in target abort sets bit 28.
// - forward: completion received with unsupported request sets bit 29.
// - reverse: mastered transaction ending in master abort sets bit 29.
// - forward: sending a fatal or non-fatal error message sets bit 30.
// - reverse: driving the system error pin sets bit 30.
// - forward: receiving a poisoned packet sets bit 31.
// - reverse: address or data parity error sets bit 31, enable or not.
// - command bit 6 is parity error response enable, reset 0, gates bit 24.
module bps_top
	import bps_pkg::*;
#(
	parameter int unsigned ADDR_W = BPS_ADDR_W
)
(
	input wire logic MCLK_IN,
	input wire logic ARST_N_IN,
	input wire logic [ADDR_W-1:0] ADDR_IN,
	input wire logic [31:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [31:0] RDATA_OUT,
	input wire logic MODE_REVERSE_IN,
	input wire logic PRIMARY_PCI_MODE_IN,
	input wire logic INTX_PENDING_IN,
	input wire logic PRIMARY_PARITY_ERROR_PIN_N_IN,
	input wire logic RV_SEND_OR_SPLIT_WR_IN,
	input wire bps_evt_t EVT_IN,
	output logic [15:0] STATUS_OUT,
	output logic PERR_RESP_EN_OUT
);

	// elaboration check: the dword offset must fit in the address
	if (ADDR_W < 3)
	begin : g_addr_check
		$error("bps_top: ADDR_W must be at least 3");
	end

	typedef struct packed {
		logic mode_s1;          // mode strap synchroniser, first stage
		logic mode_rev;         // synchronised mode
		logic pcim_s1;
		logic pci_mode;
		logic perr_s1;          // parity error pin synchroniser
		logic perr_seen;        // synchronised, active high
		logic send_d1;          // sending qualifier delayed to match the pin
		logic send_d2;
		logic perr_resp_en;
		logic [BPS_NFLAGS-1:0] flags;
		logic [31:0] rdata;
		logic [15:0] status;
	} bps_state_t;

	bps_state_t st_reg;
	bps_state_t st_next;
	logic [BPS_NFLAGS-1:0] flag_set;
	logic [BPS_NFLAGS-1:0] flag_clr;
	logic [BPS_NFLAGS-1:0] flag_upd;
	logic hit;
	logic fwd;
	logic rev;
	logic mdpe_evt;

	assign hit = (ADDR_IN == ADDR_W'(BPS_CMDSTS_OFFSET));
	assign fwd = (st_reg.mode_rev == BPS_MODE_FORWARD);
	assign rev = (st_reg.mode_rev == BPS_MODE_REVERSE);

	// per-flag event sources, each gated by the direction it belongs to
	always_comb
	begin
		mdpe_evt = (fwd && (EVT_IN.fw_cpl_poisoned_rx || EVT_IN.fw_wr_poisoned_tx))
			|| (rev && EVT_IN.rv_rd_data_perr)
			|| (rev && st_reg.perr_seen && st_reg.send_d2)
			|| (rev && EVT_IN.rv_scm_npw_perr);
		flag_set = '0;
		flag_set[BPS_F_MDPE] = st_reg.perr_resp_en && mdpe_evt;
		flag_set[BPS_F_STA] = (fwd && EVT_IN.fw_cpl_ca_tx)
			|| (rev && EVT_IN.rv_target_abort_tx);
		flag_set[BPS_F_RTA] = (fwd && EVT_IN.fw_cpl_ca_rx)
			|| (rev && EVT_IN.rv_target_abort_rx);
		flag_set[BPS_F_RMA] = (fwd && EVT_IN.fw_cpl_ur_rx)
			|| (rev && EVT_IN.rv_master_abort_rx);
		flag_set[BPS_F_SSE] = (fwd && EVT_IN.fw_err_msg_tx)
			|| (rev && EVT_IN.rv_serr_driven);
		// not gated by the response enable, unlike bit 24
		flag_set[BPS_F_DPE] = (fwd && EVT_IN.fw_poisoned_tlp_rx)
			|| (rev && EVT_IN.rv_addr_data_perr);
	end

	// write-one-to-clear per flag; a set in the same cycle wins over the clear
	for (genvar i = 0; i < BPS_NFLAGS; i++)
	begin : g_flag
		assign flag_clr[i] = WR_IN && hit && WDATA_IN[BPS_FLAG_POS[i]];
		assign flag_upd[i] = flag_set[i] || (st_reg.flags[i] && !flag_clr[i]);
	end

	// next state: synchronisers, command bit, flags, status image, read data
	always_comb
	begin
		st_next = st_reg;
		st_next.mode_s1 = MODE_REVERSE_IN;
		st_next.mode_rev = st_reg.mode_s1;
		st_next.pcim_s1 = PRIMARY_PCI_MODE_IN;
		st_next.pci_mode = st_reg.pcim_s1;
		st_next.perr_s1 = !PRIMARY_PARITY_ERROR_PIN_N_IN;
		st_next.perr_seen = st_reg.perr_s1;
		// the pin takes two cycles through the synchroniser, so the qualifier does too
		st_next.send_d1 = RV_SEND_OR_SPLIT_WR_IN;
		st_next.send_d2 = st_reg.send_d1;
		if (WR_IN && hit)
		begin
			st_next.perr_resp_en = WDATA_IN[BPS_CMD_PERR_RESP_BIT];
		end
		st_next.flags = flag_upd;
		// status image is built from the current state, so it trails by one cycle
		st_next.status = '0;
		st_next.status[BPS_STS_INTX_BIT-BPS_STS_LSB] = INTX_PENDING_IN;
		st_next.status[BPS_STS_CAPLIST_BIT-BPS_STS_LSB] = BPS_CAPLIST_VALUE;
		st_next.status[BPS_STS_66MHZ_BIT-BPS_STS_LSB] = rev;
		st_next.status[BPS_STS_FB2B_BIT-BPS_STS_LSB] = rev && st_reg.pci_mode;
		st_next.status[BPS_STS_DEVSEL_MSB-BPS_STS_LSB:BPS_STS_DEVSEL_LSB-BPS_STS_LSB] =
			rev ? BPS_DEVSEL_MEDIUM : BPS_DEVSEL_FAST;
		for (int j = 0; j < BPS_NFLAGS; j++)
		begin
			st_next.status[BPS_FLAG_POS[j]-BPS_STS_LSB] = st_reg.flags[j];
		end
		// read data stands only in the cycle after the strobe
		st_next.rdata = BPS_DATA_ZERO;
		if (RD_IN && hit)
		begin
			st_next.rdata[31:BPS_STS_LSB] = st_next.status;
			st_next.rdata[BPS_CMD_PERR_RESP_BIT] = st_reg.perr_resp_en;
		end
	end

	// single state register
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			st_reg <= '0;
			st_reg.perr_resp_en <= BPS_PERR_RESP_RESET;
			st_reg.flags <= BPS_FLAGS_RESET;
			st_reg.status[BPS_STS_CAPLIST_BIT-BPS_STS_LSB] <= BPS_CAPLIST_VALUE;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign RDATA_OUT = st_reg.rdata;
	assign STATUS_OUT = st_reg.status;
	assign PERR_RESP_EN_OUT = st_reg.perr_resp_en;

	// checks on the block's own outputs and state
	default clocking cb @(posedge MCLK_IN);
	endclocking
	default disable iff (!ARST_N_IN);

	logic past_valid;
	always_ff @(posedge MCLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			past_valid <= 1'h0;
		end
		else
		begin
			past_valid <= 1'h1;
		end
	end

	property p_intx;
		past_valid |-> STATUS_OUT[BPS_STS_INTX_BIT-BPS_STS_LSB] == $past(INTX_PENDING_IN);
	endproperty
	a_intx: assert property (p_intx) else $error("pending interrupt bit wrong");

	property p_caplist;
		STATUS_OUT[BPS_STS_CAPLIST_BIT-BPS_STS_LSB] == 1'h1;
	endproperty
	a_caplist: assert property (p_caplist) else $error("capability bit not 1");

	property p_speed_bits;
		past_valid |-> STATUS_OUT[BPS_STS_66MHZ_BIT-BPS_STS_LSB] == $past(st_reg.mode_rev)
			&& STATUS_OUT[BPS_STS_DEVSEL_MSB-BPS_STS_LSB] == 1'h0
			&& STATUS_OUT[BPS_STS_DEVSEL_LSB-BPS_STS_LSB] == $past(st_reg.mode_rev);
	endproperty
	a_speed_bits: assert property (p_speed_bits) else $error("66MHz or devsel bits wrong");

	property p_fb2b;
		past_valid && !$past(st_reg.mode_rev) |-> !STATUS_OUT[BPS_STS_FB2B_BIT-BPS_STS_LSB];
	endproperty
	a_fb2b: assert property (p_fb2b) else $error("fast back-to-back set in forward");

	property p_mdpe_gate;
		$rose(st_reg.flags[BPS_F_MDPE]) |-> $past(st_reg.perr_resp_en);
	endproperty
	a_mdpe_gate: assert property (p_mdpe_gate) else $error("bit 24 set while disabled");

	property p_fw_poison;
		fwd && st_reg.perr_resp_en && EVT_IN.fw_cpl_poisoned_rx
			|=> st_reg.flags[BPS_F_MDPE] ##1 STATUS_OUT[BPS_FLAG_POS[BPS_F_MDPE]-BPS_STS_LSB];
	endproperty
	a_fw_poison: assert property (p_fw_poison) else $error("poisoned completion lost");

	sequence s_pin_seen;
		rev && !PRIMARY_PARITY_ERROR_PIN_N_IN && RV_SEND_OR_SPLIT_WR_IN;
	endsequence
	sequence s_cfg_held;
		(rev && st_reg.perr_resp_en)[*2];
	endsequence
	property p_pin_mdpe;
		s_pin_seen ##1 s_cfg_held |=> st_reg.flags[BPS_F_MDPE];
	endproperty
	a_pin_mdpe: assert property (p_pin_mdpe) else $error("parity pin event lost");

	property p_sta;
		(fwd && EVT_IN.fw_cpl_ca_tx) || (rev && EVT_IN.rv_target_abort_tx)
			|=> st_reg.flags[BPS_F_STA];
	endproperty
	a_sta: assert property (p_sta) else $error("signaled target abort lost");

	property p_rma_mode;
		fwd && EVT_IN.rv_master_abort_rx && !EVT_IN.fw_cpl_ur_rx && !st_reg.flags[BPS_F_RMA]
			|=> !st_reg.flags[BPS_F_RMA];
	endproperty
	a_rma_mode: assert property (p_rma_mode) else $error("reverse event set flag in forward");

	property p_dpe_ungated;
		rev && EVT_IN.rv_addr_data_perr |=> st_reg.flags[BPS_F_DPE];
	endproperty
	a_dpe_ungated: assert property (p_dpe_ungated) else $error("detected parity error lost");

	property p_sse;
		fwd && EVT_IN.fw_err_msg_tx |=> st_reg.flags[BPS_F_SSE];
	endproperty
	a_sse: assert property (p_sse) else $error("signaled system error lost");

	property p_w1c_clear;
		WR_IN && hit && WDATA_IN[BPS_FLAG_POS[BPS_F_RTA]] && !flag_set[BPS_F_RTA]
			|=> !st_reg.flags[BPS_F_RTA];
	endproperty
	a_w1c_clear: assert property (p_w1c_clear) else $error("write one did not clear");

	property p_w1c_hold;
		st_reg.flags[BPS_F_DPE] && !(WR_IN && hit && WDATA_IN[BPS_FLAG_POS[BPS_F_DPE]])
			|=> st_reg.flags[BPS_F_DPE];
	endproperty
	a_w1c_hold: assert property (p_w1c_hold) else $error("flag dropped without clear");

	property p_perr_en;
		WR_IN && hit |=> st_reg.perr_resp_en == $past(WDATA_IN[BPS_CMD_PERR_RESP_BIT]);
	endproperty
	a_perr_en: assert property (p_perr_en) else $error("response enable not written");

	property p_read_once;
		!RD_IN |=> RDATA_OUT == BPS_DATA_ZERO;
	endproperty
	a_read_once: assert property (p_read_once) else $error("read data outside read slot");

	// per-event checks: each qualified source sets its flag at the next edge
	property p_fw_poison_tx;
		fwd && st_reg.perr_resp_en && EVT_IN.fw_wr_poisoned_tx |=> st_reg.flags[BPS_F_MDPE];
	endproperty
	a_fw_poison_tx: assert property (p_fw_poison_tx) else $error("poisoned write lost");

	property p_rv_read_perr;
		rev && st_reg.perr_resp_en && EVT_IN.rv_rd_data_perr |=> st_reg.flags[BPS_F_MDPE];
	endproperty
	a_rv_read_perr: assert property (p_rv_read_perr) else $error("read parity error lost");

	property p_rv_scm;
		rev && st_reg.perr_resp_en && EVT_IN.rv_scm_npw_perr |=> st_reg.flags[BPS_F_MDPE];
	endproperty
	a_rv_scm: assert property (p_rv_scm) else $error("split message parity error lost");

	property p_rta;
		(fwd && EVT_IN.fw_cpl_ca_rx) || (rev && EVT_IN.rv_target_abort_rx)
			|=> st_reg.flags[BPS_F_RTA];
	endproperty
	a_rta: assert property (p_rta) else $error("received target abort lost");

	property p_rma;
		(fwd && EVT_IN.fw_cpl_ur_rx) || (rev && EVT_IN.rv_master_abort_rx)
			|=> st_reg.flags[BPS_F_RMA];
	endproperty
	a_rma: assert property (p_rma) else $error("received master abort lost");

	property p_rv_sse;
		rev && EVT_IN.rv_serr_driven |=> st_reg.flags[BPS_F_SSE];
	endproperty
	a_rv_sse: assert property (p_rv_sse) else $error("system error pin event lost");

	property p_fw_dpe;
		fwd && EVT_IN.fw_poisoned_tlp_rx |=> st_reg.flags[BPS_F_DPE];
	endproperty
	a_fw_dpe: assert property (p_fw_dpe) else $error("poisoned packet event lost");

	// wrong-direction events alone must leave a clear flag clear; the other source is held low
	property p_sta_mode;
		fwd && EVT_IN.rv_target_abort_tx && !EVT_IN.fw_cpl_ca_tx && !st_reg.flags[BPS_F_STA]
			|=> !st_reg.flags[BPS_F_STA];
	endproperty
	a_sta_mode: assert property (p_sta_mode) else $error("reverse abort set flag in forward");

	property p_rta_mode;
		fwd && EVT_IN.rv_target_abort_rx && !EVT_IN.fw_cpl_ca_rx && !st_reg.flags[BPS_F_RTA]
			|=> !st_reg.flags[BPS_F_RTA];
	endproperty
	a_rta_mode: assert property (p_rta_mode) else $error("reverse event set bit 28");

	property p_sse_mode;
		rev && EVT_IN.fw_err_msg_tx && !EVT_IN.rv_serr_driven && !st_reg.flags[BPS_F_SSE]
			|=> !st_reg.flags[BPS_F_SSE];
	endproperty
	a_sse_mode: assert property (p_sse_mode) else $error("forward event set bit 30");

	property p_dpe_mode;
		rev && EVT_IN.fw_poisoned_tlp_rx && !EVT_IN.rv_addr_data_perr && !st_reg.flags[BPS_F_DPE]
			|=> !st_reg.flags[BPS_F_DPE];
	endproperty
	a_dpe_mode: assert property (p_dpe_mode) else $error("forward event set bit 31");

	// response enable: no retroactive set, and only a decoded write may change it
	property p_mdpe_blocked;
		!st_reg.perr_resp_en && !st_reg.flags[BPS_F_MDPE] |=> !st_reg.flags[BPS_F_MDPE];
	endproperty
	a_mdpe_blocked: assert property (p_mdpe_blocked) else $error("bit 24 set while gated");

	property p_en_hold;
		!(WR_IN && hit) |=> $stable(st_reg.perr_resp_en);
	endproperty
	a_en_hold: assert property (p_en_hold) else $error("response enable changed alone");

	// status image and read data
	property p_fb2b_rev;
		past_valid |-> STATUS_OUT[BPS_STS_FB2B_BIT-BPS_STS_LSB]
			== ($past(st_reg.mode_rev) && $past(st_reg.pci_mode));
	endproperty
	a_fb2b_rev: assert property (p_fb2b_rev) else $error("fast back-to-back bit wrong");

	for (genvar k = 0; k < BPS_NFLAGS; k++)
	begin : g_flag_chk
		property p_flag_mirror;
			past_valid |-> STATUS_OUT[BPS_FLAG_POS[k]-BPS_STS_LSB] == $past(st_reg.flags[k]);
		endproperty
		a_flag_mirror: assert property (p_flag_mirror) else $error("status flag image wrong");
	end

	property p_read_data;
		RD_IN && hit |=> RDATA_OUT[BPS_STS_INTX_BIT] == $past(INTX_PENDING_IN)
			&& RDATA_OUT[BPS_STS_CAPLIST_BIT] == BPS_CAPLIST_VALUE
			&& RDATA_OUT[BPS_CMD_PERR_RESP_BIT] == $past(st_reg.perr_resp_en);
	endproperty
	a_read_data: assert property (p_read_data) else $error("read data fields wrong");

	property p_read_miss;
		RD_IN && !hit |=> RDATA_OUT == BPS_DATA_ZERO;
	endproperty
	a_read_miss: assert property (p_read_miss) else $error("undecoded read returned data");

endmodule // bps_top

// File: tb/bps_partner.sv
module bps_partner
	import bps_pkg::*;
(
	input wire logic clk_in,
	output bps_evt_t evt_out,
	output logic perr_n_out,
	output logic send_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle far side: no events, parity pin pulled up, nothing being sent
	initial
	begin
		evt_out = '0;
		perr_n_out = 1'b1;
		send_out = 1'b0;
	end

	// one-cycle event pulse, as the forwarding logic raises it
	task automatic fire(input int k);
		@(posedge clk_in);
		evt_out[13-k] <= 1'b1;
		@(posedge clk_in);
		evt_out <= '0;
	endtask

	// pin held low two cycles so a slow synchroniser edge cannot miss it
	task automatic pin(input logic snd);
		@(posedge clk_in);
		perr_n_out <= 1'b0;
		send_out <= snd;
		repeat (2) @(posedge clk_in);
		perr_n_out <= 1'b1;  // pull-up restores the idle level
		send_out <= 1'b0;
	endtask
endmodule // bps_partner

// File: tb/testbench.sv
module testbench;
	import bps_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic mclk, arst_n, wr, rd, rev, pci, intx, perr_en, perr_n, send;
	logic [7:0] addr;
	logic [31:0] wdata, rdata;
	logic [15:0] status;
	bps_evt_t evt;
	int n_fail = 0;
	int samples_checked = 0;
	int flag [BPS_NFLAGS];
	int en = 0;
	// flag index set by each event, in struct field order
	int evf [14] = '{0, 0, 1, 2, 3, 4, 5, 0, 0, 1, 2, 3, 4, 5};

	bps_top #(.ADDR_W(8)) uut (.MCLK_IN(mclk), .ARST_N_IN(arst_n), .ADDR_IN(addr),
		.WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
		.MODE_REVERSE_IN(rev), .PRIMARY_PCI_MODE_IN(pci), .INTX_PENDING_IN(intx),
		.PRIMARY_PARITY_ERROR_PIN_N_IN(perr_n), .RV_SEND_OR_SPLIT_WR_IN(send),
		.EVT_IN(evt), .STATUS_OUT(status), .PERR_RESP_EN_OUT(perr_en));
	bps_partner p (.clk_in(mclk), .evt_out(evt), .perr_n_out(perr_n), .send_out(send));

	// status image expected from the model state
	function automatic logic [15:0] exp_status();
		logic [15:0] s;
		s = 16'h0010;
		s[BPS_STS_INTX_BIT-BPS_STS_LSB] = intx;
		s[BPS_STS_66MHZ_BIT-BPS_STS_LSB] = rev;
		s[BPS_STS_FB2B_BIT-BPS_STS_LSB] = rev & pci;
		s[BPS_STS_DEVSEL_LSB-BPS_STS_LSB] = rev;  // medium decode only in reverse
		for (int f = 0; f < BPS_NFLAGS; f++)
			s[BPS_FLAG_POS[f]-BPS_STS_LSB] = (flag[f] != 0);
		return s;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		if (n_fail == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// single-cycle write; the model follows only decoded writes
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		if (a == BPS_CMDSTS_OFFSET)
		begin
			en = d[BPS_CMD_PERR_RESP_BIT];
			for (int f = 0; f < BPS_NFLAGS; f++)
				if (d[BPS_FLAG_POS[f]])
					flag[f] = 0;
		end
	endtask

	// read data must stand in the next cycle only
	task automatic bus_rd(input logic [7:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		check(rdata, (a == BPS_CMDSTS_OFFSET) ? {exp_status(), 9'h000, en[0], 6'h00} : BPS_DATA_ZERO);
		@(posedge mclk);
		#1;
		check(rdata, BPS_DATA_ZERO);
	endtask

	// pulses need a few cycles to reach the status image, mode straps longer
	task automatic settle_check();
		repeat (5) @(posedge mclk);
		#1;
		check({status, 15'h0000, perr_en}, {exp_status(), 15'h0000, en[0]});
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// watchdog: the random run takes well under a fifth of this span
	initial
	begin
		repeat (30000) @(posedge mclk);
		n_fail++;
		stop_test();
	end

	initial
	begin
		int op;
		logic [7:0] a;
		logic snd;
		arst_n = 1'b0;
		{wr, rd, rev, pci, intx} = 5'h00;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		op = $urandom(32'h0BAA2863);
		repeat (20) @(posedge mclk);
		#1;
		check({rdata[15:0], status}, 32'h0000_0010);
		for (int pass = 0; pass < 2; pass++)
		begin
			@(posedge mclk);
			arst_n <= 1'b1;
			settle_check();
			for (int step = 0; step < 300; step++)
			begin
				@(posedge mclk);
				intx <= 1'($urandom_range(1));
				op = $urandom_range(19);
				a = 8'($urandom_range(255));
				if (a == BPS_CMDSTS_OFFSET)
					a = 8'h08;
				if (op < 14)
				begin
					p.fire(op);
					if ((op < 7) == (rev == 1'b0) && (evf[op] != 0 || en != 0))
						flag[evf[op]] = 1;
				end
				else if (op == 14)
				begin
					wdata <= 32'($urandom);  // stray data while no strobe is high
					// pin pulses without the send qualifier must leave bit 24 alone
					snd = 1'($urandom_range(1));
					p.pin(snd);
					if (rev && en != 0 && snd)
						flag[0] = 1;
				end
				else if (op == 15)
					bus_wr(BPS_CMDSTS_OFFSET, $urandom & $urandom);
				else if (op == 16)
					bus_rd(BPS_CMDSTS_OFFSET);
				else if (op == 17)
					bus_rd(a);
				else if (op == 18)
				begin
					rev <= 1'($urandom_range(1));
					pci <= 1'($urandom_range(1));
				end
				else
					bus_wr(a, 32'hFFFF_FFFF);
				settle_check();
			end
			// reset in mid-run clears every flag and the enable at once
			#3;
			arst_n = 1'b0;
			#1;
			check({rdata[15:0], status}, 32'h0000_0010);
			en = 0;
			for (int f = 0; f < BPS_NFLAGS; f++)
				flag[f] = 0;
		end
		stop_test();
	end
endmodule // testbench
